// ==== dvic_pkg.sv ====
package dvic_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int VEC_W  = 9;
	localparam int SW_W   = 6;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ISTAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h0C;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_RXIE = 0; // receive_interrupt_enable
	localparam int CTRL_TXIE = 1; // transmit_interrupt_enable
	localparam int CTRL_LSIE = 2; // line_status_interrupt_enable
	localparam int CTRL_W    = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

	// ----------------------------------------------------------------
	// state register fields
	// ----------------------------------------------------------------
	localparam int ST_REQRX = 0;
	localparam int ST_REQTX = 1;
	localparam int ST_SEL   = 2;
	localparam int ST_BREQ  = 3;
	localparam int ST_BUSY  = 4;
	localparam int ST_FSM   = 5; // two bits
	localparam int ST_SW    = 8; // six bits

	// ----------------------------------------------------------------
	// interrupt status / mask fields
	// ----------------------------------------------------------------
	localparam int EV_RXREQ = 0;
	localparam int EV_TXREQ = 1;
	localparam int EV_VEC   = 2;
	localparam int EV_W     = 3;
	localparam logic [EV_W-1:0] EV_RST = 3'h0;

	// ----------------------------------------------------------------
	// vector layout
	// ----------------------------------------------------------------
	localparam int VEC_SEL_BIT = 2;
	localparam int VEC_SW_LSB  = 3;
	localparam logic [1:0] VEC_LOW_ZERO = 2'h0;
	localparam logic       SEL_RX = 1'b0; // vector ends in octal 0
	localparam logic       SEL_TX = 1'b1; // vector ends in octal 4

	// ----------------------------------------------------------------
	// axi responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int REQ_DELAY_NS  = 100;
	localparam int REQ_DELAY_CYC =
		(REQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// grant sequencer states, gray along the path
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'h0,
		SEQ_GRANT   = 2'h1,
		SEQ_DRIVE   = 2'h3,
		SEQ_RELEASE = 2'h2
	} dvic_state_t;

endpackage : dvic_pkg

// ==== dvic_delay_line.sv ====
`timescale 1ns/1ps

// fixed-length delay of a single level, one flop per cycle
module dvic_delay_line #(
	parameter int DEPTH = 3
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic levelIn,
	output logic      levelOut
);

	logic [DEPTH-1:0] stage_r;

	// ----------------------------------------------------------------
	// shift chain
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++)
		begin : g_stage
			// one stage per cycle
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
					stage_r[i] <= 1'b0;
				else if (i == 0)
					stage_r[i] <= levelIn;
				else
					stage_r[i] <= stage_r[(i == 0) ? 0 : i-1];
			end
		end
	endgenerate

	assign levelOut = stage_r[DEPTH-1];

endmodule : dvic_delay_line

// ==== dvic_top.sv ====
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module dvic_top #(
	parameter int REQ_DELAY = dvic_pkg::REQ_DELAY_CYC
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	// axi4-lite slave
	input  wire logic [dvic_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [dvic_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [dvic_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [dvic_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// request sources
	input  wire logic                        transmitDoneFlag,
	input  wire logic                        receiveDoneFlag,
	input  wire logic                        lineStatusChangeFlag,
	input  wire logic                        receiveStatusRead,
	input  wire logic [dvic_pkg::SW_W-1:0]   vectorSwitch,
	// host bus arbitration and vector lines
	output logic                             busRequest,
	input  wire logic                        busGrantIn,
	output logic                             busGrantOut,
	output logic                             busBusy,
	input  wire logic                        vectorTaken,
	output logic [dvic_pkg::VEC_W-1:0]       vectorData,
	output logic [dvic_pkg::VEC_W-1:0]       vectorDataOe,
	output logic                             irq
);

	logic                          awHeld_r;
	logic                          wHeld_r;
	logic [dvic_pkg::ADDR_W-1:0]   awAddr_r;
	logic [dvic_pkg::DATA_W-1:0]   wData_r;
	logic [3:0]                    wStrb_r;
	logic                          bValid_r;
	logic [1:0]                    bResp_r;
	logic                          rValid_r;
	logic [1:0]                    rResp_r;
	logic [dvic_pkg::DATA_W-1:0]   rData_r;
	logic [dvic_pkg::DATA_W-1:0]   rData_nxt;
	logic                          rHit;
	logic                          wrFire;
	logic                          wHit;
	logic [dvic_pkg::CTRL_W-1:0]   ctrl_r;
	logic [dvic_pkg::EV_W-1:0]     iStat_r;
	logic [dvic_pkg::EV_W-1:0]     iMask_r;
	logic [dvic_pkg::EV_W-1:0]     evSet;
	logic [dvic_pkg::EV_W-1:0]     evClr;
	logic                          irq_r;
	logic                          rxCond;
	logic                          rxCondDly;
	logic                          txCond;
	logic                          reqRx_r;
	logic                          reqTx_r;
	logic                          requesting;
	logic                          vecSelFlop_r;
	logic                          busy_r;
	logic                          grantTake;
	logic                          serviceDone;
	logic [dvic_pkg::VEC_W-1:0]    vec_r;
	logic [dvic_pkg::VEC_W-1:0]    vecOe_r;
	logic [dvic_pkg::VEC_W-1:0]    vec_nxt;
	dvic_pkg::dvic_state_t         state_r;

	// ----------------------------------------------------------------
	// axi write channel
	// ----------------------------------------------------------------
	assign s_axi_awready = ~awHeld_r;
	assign s_axi_wready  = ~wHeld_r;
	assign wrFire        = awHeld_r & wHeld_r & ~bValid_r;
	assign s_axi_bvalid  = bValid_r;
	assign s_axi_bresp   = bResp_r;

	// address capture, either order with data
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			awHeld_r <= 1'b0;
			awAddr_r <= '0;
		end
		else if (s_axi_awvalid && !awHeld_r)
		begin
			awHeld_r <= 1'b1;
			awAddr_r <= s_axi_awaddr;
		end
		else if (wrFire)
			awHeld_r <= 1'b0;
	end

	// data capture
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wHeld_r <= 1'b0;
			wData_r <= '0;
			wStrb_r <= '0;
		end
		else if (s_axi_wvalid && !wHeld_r)
		begin
			wHeld_r <= 1'b1;
			wData_r <= s_axi_wdata;
			wStrb_r <= s_axi_wstrb;
		end
		else if (wrFire)
			wHeld_r <= 1'b0;
	end

	// write address decode
	always_comb
	begin
		if (awAddr_r == dvic_pkg::OFS_CTRL)
			wHit = 1'b1;
		else if (awAddr_r == dvic_pkg::OFS_STATE)
			wHit = 1'b1;
		else if (awAddr_r == dvic_pkg::OFS_ISTAT)
			wHit = 1'b1;
		else if (awAddr_r == dvic_pkg::OFS_IMASK)
			wHit = 1'b1;
		else
			wHit = 1'b0;
	end

	// write response
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			bValid_r <= 1'b0;
			bResp_r  <= dvic_pkg::RESP_OKAY;
		end
		else if (wrFire)
		begin
			bValid_r <= 1'b1;
			bResp_r  <= wHit ? dvic_pkg::RESP_OKAY : dvic_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bValid_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// control enables, low byte lane only
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			ctrl_r <= dvic_pkg::CTRL_RST;
		else if (wrFire && wStrb_r[0] && awAddr_r == dvic_pkg::OFS_CTRL)
			ctrl_r <= wData_r[dvic_pkg::CTRL_W-1:0];
	end

	// interrupt mask
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			iMask_r <= dvic_pkg::EV_RST;
		else if (wrFire && wStrb_r[0] && awAddr_r == dvic_pkg::OFS_IMASK)
			iMask_r <= wData_r[dvic_pkg::EV_W-1:0];
	end

	// write-one-to-clear, a new event wins over the clear
	assign evClr = (wrFire && wStrb_r[0] && awAddr_r == dvic_pkg::OFS_ISTAT)
		? wData_r[dvic_pkg::EV_W-1:0] : '0;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			iStat_r <= dvic_pkg::EV_RST;
		else
			iStat_r <= (iStat_r & ~evClr) | evSet;
	end

	// level interrupt output
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			irq_r <= 1'b0;
		else
			irq_r <= |(iStat_r & iMask_r);
	end
	assign irq = irq_r;

	// ----------------------------------------------------------------
	// axi read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = ~rValid_r;
	assign s_axi_rvalid  = rValid_r;
	assign s_axi_rdata   = rData_r;
	assign s_axi_rresp   = rResp_r;

	// read address decode
	always_comb
	begin
		rData_nxt = '0;
		rHit      = 1'b1;
		if (s_axi_araddr == dvic_pkg::OFS_CTRL)
			rData_nxt[dvic_pkg::CTRL_W-1:0] = ctrl_r;
		else if (s_axi_araddr == dvic_pkg::OFS_STATE)
		begin
			rData_nxt[dvic_pkg::ST_REQRX] = reqRx_r;
			rData_nxt[dvic_pkg::ST_REQTX] = reqTx_r;
			rData_nxt[dvic_pkg::ST_SEL]   = vecSelFlop_r;
			rData_nxt[dvic_pkg::ST_BREQ]  = busRequest;
			rData_nxt[dvic_pkg::ST_BUSY]  = busy_r;
			rData_nxt[dvic_pkg::ST_FSM +: 2] = state_r;
			rData_nxt[dvic_pkg::ST_SW +: dvic_pkg::SW_W] = vectorSwitch;
		end
		else if (s_axi_araddr == dvic_pkg::OFS_ISTAT)
			rData_nxt[dvic_pkg::EV_W-1:0] = iStat_r;
		else if (s_axi_araddr == dvic_pkg::OFS_IMASK)
			rData_nxt[dvic_pkg::EV_W-1:0] = iMask_r;
		else
			rHit = 1'b0;
	end

	// read data and response
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rValid_r <= 1'b0;
			rData_r  <= '0;
			rResp_r  <= dvic_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && !rValid_r)
		begin
			rValid_r <= 1'b1;
			rData_r  <= rData_nxt;
			rResp_r  <= rHit ? dvic_pkg::RESP_OKAY : dvic_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rValid_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// request conditions
	// ----------------------------------------------------------------
	assign txCond = transmitDoneFlag & ctrl_r[dvic_pkg::CTRL_TXIE];
	assign rxCond = ((receiveDoneFlag & ctrl_r[dvic_pkg::CTRL_RXIE])
		| (lineStatusChangeFlag & ctrl_r[dvic_pkg::CTRL_LSIE]))
		& ~receiveStatusRead;

	// settling delay on the receive request
	dvic_delay_line #(
		.DEPTH    (REQ_DELAY)
	) u_rxDelay (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.levelIn  (rxCond),
		.levelOut (rxCondDly)
	);

	assign grantTake   = (state_r == dvic_pkg::SEQ_IDLE) & busGrantIn
		& requesting;
	assign serviceDone = (state_r == dvic_pkg::SEQ_DRIVE) & vectorTaken;

	// ----------------------------------------------------------------
	// request latches
	// ----------------------------------------------------------------
	// receive latch follows its condition while idle
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			reqRx_r <= 1'b0;
		else if (serviceDone && vecSelFlop_r == dvic_pkg::SEL_RX)
			reqRx_r <= 1'b0;
		else if (state_r == dvic_pkg::SEQ_IDLE)
			reqRx_r <= rxCondDly;
	end

	// transmit latch
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			reqTx_r <= 1'b0;
		else if (serviceDone && vecSelFlop_r == dvic_pkg::SEL_TX)
			reqTx_r <= 1'b0;
		else if (state_r == dvic_pkg::SEQ_IDLE)
			reqTx_r <= txCond;
	end

	assign requesting = reqRx_r | reqTx_r;

	// event pulses for the status register
	assign evSet[dvic_pkg::EV_RXREQ] = (state_r == dvic_pkg::SEQ_IDLE)
		& rxCondDly & ~reqRx_r;
	assign evSet[dvic_pkg::EV_TXREQ] = (state_r == dvic_pkg::SEQ_IDLE)
		& txCond & ~reqTx_r;
	assign evSet[dvic_pkg::EV_VEC]   = serviceDone;

	// ----------------------------------------------------------------
	// arbitration
	// ----------------------------------------------------------------
	assign busRequest  = requesting & (state_r == dvic_pkg::SEQ_IDLE);
	// grant passes on only when not requesting
	assign busGrantOut = busGrantIn & ~requesting
		& (state_r == dvic_pkg::SEQ_IDLE);
	assign busBusy     = busy_r;

	// select flop, receive wins a tie
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			vecSelFlop_r <= dvic_pkg::SEL_RX;
		else if (grantTake)
			vecSelFlop_r <= reqRx_r ? dvic_pkg::SEL_RX
				: dvic_pkg::SEL_TX;
	end

	// grant sequencer
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state_r <= dvic_pkg::SEQ_IDLE;
		else
		begin
			case (state_r)
				dvic_pkg::SEQ_IDLE:
					if (grantTake)
						state_r <= dvic_pkg::SEQ_GRANT;
				dvic_pkg::SEQ_GRANT:
					state_r <= dvic_pkg::SEQ_DRIVE;
				dvic_pkg::SEQ_DRIVE:
					if (vectorTaken)
						state_r <= dvic_pkg::SEQ_RELEASE;
				dvic_pkg::SEQ_RELEASE:
					if (!busGrantIn)
						state_r <= dvic_pkg::SEQ_IDLE;
				default:
					state_r <= dvic_pkg::SEQ_IDLE;
			endcase
		end
	end

	// bus mastership flag
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			busy_r <= 1'b0;
		else if (grantTake)
			busy_r <= 1'b1;
		else if (serviceDone)
			busy_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// vector drivers
	// ----------------------------------------------------------------
	// switches above, select flop at bit 2, zeros below
	assign vec_nxt = {vectorSwitch, vecSelFlop_r,
		dvic_pkg::VEC_LOW_ZERO};

	// open-drain: a one is driven, a zero is left floating
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			vec_r   <= '0;
			vecOe_r <= '0;
		end
		else if (state_r == dvic_pkg::SEQ_GRANT)
		begin
			vec_r   <= vec_nxt;
			vecOe_r <= vec_nxt;
		end
		else if (state_r != dvic_pkg::SEQ_DRIVE || vectorTaken)
		begin
			vec_r   <= '0;
			vecOe_r <= '0;
		end
	end

	assign vectorData   = vec_r;
	assign vectorDataOe = vecOe_r;

endmodule : dvic_top

// ==== dvic_top_assertions.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker for the vector interrupt block
// ----------------------------------------------------------------
module dvic_top_checker (
	input wire logic                        sys_clk,
	input wire logic                        rst,
	input wire logic                        busRequest,
	input wire logic                        busGrantIn,
	input wire logic                        busGrantOut,
	input wire logic                        busBusy,
	input wire logic                        vectorTaken,
	input wire logic [dvic_pkg::VEC_W-1:0]  vectorData,
	input wire logic [dvic_pkg::VEC_W-1:0]  vectorDataOe,
	input wire logic [dvic_pkg::SW_W-1:0]   vectorSwitch
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// grant taken, then mastership, then the vector on the lines
	sequence s_accept;
		busGrantIn && busRequest;
	endsequence
	sequence s_deliver;
		busBusy ##1 (busBusy && vectorDataOe == vectorData
			&& vectorData[8:3] == vectorSwitch);
	endsequence

	property p_low_zero;
		vectorData[1:0] == 2'h0 && vectorDataOe[1:0] == 2'h0;
	endproperty
	property p_sw;
		(vectorDataOe != 9'h0) |-> vectorData[8:3] == vectorSwitch;
	endproperty
	property p_oe_busy;
		(vectorDataOe != 9'h0) |-> busBusy;
	endproperty
	property p_accept;
		s_accept |=> s_deliver;
	endproperty
	property p_req_drop;
		s_accept |=> !busRequest;
	endproperty
	property p_pass;
		busGrantOut |-> busGrantIn && !busRequest;
	endproperty
	property p_absorb;
		busRequest && busGrantIn |-> !busGrantOut;
	endproperty
	property p_busy_hold;
		busBusy && !vectorTaken |=> busBusy;
	endproperty
	property p_busy_end;
		busBusy && $past(busBusy) && vectorTaken
			|=> !busBusy && vectorDataOe == 9'h0;
	endproperty

	a_low_zero: assert property (p_low_zero)
		else $error("low vector bits not zero");
	a_sw: assert property (p_sw)
		else $error("upper vector bits differ from switches");
	a_oe_busy: assert property (p_oe_busy)
		else $error("vector lines driven without mastership");
	a_accept: assert property (p_accept)
		else $error("vector not driven after grant");
	a_req_drop: assert property (p_req_drop)
		else $error("request held after grant taken");
	a_pass: assert property (p_pass)
		else $error("grant passed on while requesting");
	a_absorb: assert property (p_absorb)
		else $error("grant not absorbed");
	a_busy_hold: assert property (p_busy_hold)
		else $error("mastership dropped before vector taken");
	a_busy_end: assert property (p_busy_end)
		else $error("lines not released after vector taken");
endmodule : dvic_top_checker

// ==== dvic_host_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host processor and grant arbiter model
// ----------------------------------------------------------------
module dvic_host_model (
	input  wire logic                       sys_clk,
	input  wire logic                       rst,
	input  wire logic                       busRequest,
	input  wire logic                       busBusy,
	input  wire logic [dvic_pkg::VEC_W-1:0] vectorDataOe,
	input  wire logic                       grantEn,
	input  wire logic [3:0]                 holdCyc,
	output logic                            hostGrant,
	output logic                            vectorTaken,
	output logic [dvic_pkg::VEC_W-1:0]      vecSeen,
	output logic [7:0]                      vecCount
);
	logic [3:0] waitCnt_r;
	logic [3:0] prioCnt_r;

	// grant on request, withheld while mastered or at raised priority
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			hostGrant <= 1'b0;
		else if (busBusy || prioCnt_r != 4'h0)
			hostGrant <= 1'b0;
		else
			hostGrant <= busRequest && grantEn;

	// vector fetch after holdCyc cycles; released lines read as 0
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			vectorTaken <= 1'b0;
			waitCnt_r   <= 4'h0;
			vecSeen     <= 9'h0;
			vecCount    <= 8'h0;
		end
		else if (vectorTaken)
		begin
			// word at vecSeen: routine, next word: status at raised level
			vecSeen     <= vectorDataOe;
			vecCount    <= vecCount + 8'h1;
			vectorTaken <= 1'b0;
			waitCnt_r   <= 4'h0;
		end
		else if (busBusy && waitCnt_r == holdCyc)
			vectorTaken <= 1'b1;
		else if (busBusy)
			waitCnt_r <= waitCnt_r + 4'h1;

	// routine runs at raised priority for holdCyc cycles, no new grant
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			prioCnt_r <= 4'h0;
		else if (vectorTaken)
			prioCnt_r <= holdCyc;
		else if (prioCnt_r != 4'h0)
			prioCnt_r <= prioCnt_r - 4'h1;
endmodule : dvic_host_model

// ==== tb_dual_vector_interrupt_control.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module tb_dual_vector_interrupt_control;
	localparam int RD = 2;
	localparam logic [5:0] SWT [3] = '{6'h18, 6'h19, 6'h3F};
	localparam logic [2:0] SRC [3] = '{3'h2, 3'h4, 3'h1};
	localparam logic [2:0] ENT [3] = '{3'h1, 3'h4, 3'h2};
	localparam logic [2:0] MKT [3] = '{3'h7, 3'h0, 3'h7};
	localparam logic [2:0] EVT [3] = '{3'h5, 3'h5, 3'h6};
	logic        sys_clk, rst, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr, vecCount, nVec;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [2:0]  src;
	logic [5:0]  sw;
	logic [8:0]  vData, vOe, vecSeen;
	logic [3:0]  holdCyc, strb;
	logic        rsRead, grantEn, passGnt, hostGnt, busGrantIn, irq;
	logic        busRequest, busGrantOut, busBusy, vectorTaken;
	int          errors, n_tests;

	assign busGrantIn = hostGnt | passGnt;

	dvic_top #(.REQ_DELAY(RD)) dut_u (.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.transmitDoneFlag(src[0]), .receiveDoneFlag(src[1]),
		.lineStatusChangeFlag(src[2]), .receiveStatusRead(rsRead),
		.vectorSwitch(sw), .busRequest(busRequest),
		.busGrantIn(busGrantIn), .busGrantOut(busGrantOut),
		.busBusy(busBusy), .vectorTaken(vectorTaken),
		.vectorData(vData), .vectorDataOe(vOe), .irq(irq));

	dvic_host_model host_u (.sys_clk(sys_clk), .rst(rst),
		.busRequest(busRequest), .busBusy(busBusy), .vectorDataOe(vOe),
		.grantEn(grantEn), .holdCyc(holdCyc), .hostGrant(hostGnt),
		.vectorTaken(vectorTaken), .vecSeen(vecSeen),
		.vecCount(vecCount));

	// clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	task automatic give_up(input string nm);
		errors++;
		$display("ERROR %s expected done seen timeout", nm);
		test_done();
	endtask : give_up

	// axi write: both channels offered together, response awaited
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = dvic_pkg::RESP_OKAY);
		int k;
		@(posedge sys_clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (k = 0; k < 40; k++)
		begin
			@(posedge sys_clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		if (k == 40)
			give_up("bvalid");
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr

	// axi read with expected data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er = dvic_pkg::RESP_OKAY);
		int k;
		@(posedge sys_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (k = 0; k < 40; k++)
		begin
			@(posedge sys_clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		if (k == 40)
			give_up("rvalid");
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk("rdata", ed, rdata);
	endtask : rd

	// bounded waits for mastership and for a fetched vector
	task automatic wait_busy();
		int k;
		for (k = 0; k < 60 && busBusy !== 1'b1; k++)
			@(posedge sys_clk);
		if (busBusy !== 1'b1)
			give_up("busBusy");
	endtask : wait_busy

	task automatic wait_vec(input logic [7:0] n);
		int k;
		for (k = 0; k < 60 && vecCount !== n; k++)
			@(posedge sys_clk);
		if (vecCount !== n)
			give_up("vecCount");
	endtask : wait_vec

	// main sequence
	initial
	begin
		int i;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, src, nVec} = 59'h0;
		{rsRead, passGnt} = 2'h0;
		grantEn = 1'b1;
		holdCyc = 4'h4;
		strb = 4'hF;
		sw = 6'h18;
		rst = 1'b1;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		rd(dvic_pkg::OFS_CTRL, 32'h0);
		rd(dvic_pkg::OFS_ISTAT, 32'h0);
		rd(dvic_pkg::OFS_IMASK, 32'h0);
		rd(dvic_pkg::OFS_STATE, 32'h1800);
		wr(dvic_pkg::OFS_STATE, 32'hFF);
		rd(dvic_pkg::OFS_STATE, 32'h1800);
		wr(8'h10, 32'h1, dvic_pkg::RESP_SLVERR);
		rd(8'h10, 32'h0, dvic_pkg::RESP_SLVERR);
		strb <= 4'hE;
		wr(dvic_pkg::OFS_IMASK, 32'h7);
		strb <= 4'hF;
		rd(dvic_pkg::OFS_IMASK, 32'h0);
		$display("test registers done");
		for (i = 0; i < 3; i++)
		begin
			@(posedge sys_clk);
			sw <= SWT[i];
			holdCyc <= (i == 2) ? 4'h0 : 4'h4;
			wr(dvic_pkg::OFS_CTRL, {29'h0, ENT[i]});
			wr(dvic_pkg::OFS_IMASK, {29'h0, MKT[i]});
			rd(dvic_pkg::OFS_IMASK, {29'h0, MKT[i]});
			@(posedge sys_clk);
			src <= SRC[i];
			wait_busy();
			src <= 3'h0;
			nVec = nVec + 8'h1;
			wait_vec(nVec);
			chk("vector", {23'h0, SWT[i], i == 2, 2'h0}, {23'h0, vecSeen});
			rd(dvic_pkg::OFS_ISTAT, {29'h0, EVT[i]});
			chk("irq", {31'h0, MKT[i] != 3'h0}, {31'h0, irq});
			wr(dvic_pkg::OFS_ISTAT, 32'h7);
			rd(dvic_pkg::OFS_ISTAT, 32'h0);
			chk("irq clear", 32'h0, {31'h0, irq});
			$display("test source %0d done", i);
		end
		// receive request held off while its status is read
		holdCyc <= 4'h4;
		grantEn <= 1'b0;
		rsRead <= 1'b1;
		wr(dvic_pkg::OFS_CTRL, 32'h1);
		src <= 3'h2;
		repeat (6) @(posedge sys_clk);
		#1 chk("blocked", 32'h0, {31'h0, busRequest});
		@(posedge sys_clk);
		rsRead <= 1'b0;
		repeat (RD) @(posedge sys_clk);
		#1 chk("early", 32'h0, {31'h0, busRequest});
		@(posedge sys_clk);
		#1 chk("delayed", 32'h1, {31'h0, busRequest});
		rd(dvic_pkg::OFS_STATE, 32'h3F0D);
		@(posedge sys_clk);
		grantEn <= 1'b1;
		wait_busy();
		src <= 3'h0;
		nVec = nVec + 8'h1;
		wait_vec(nVec);
		chk("rx vector", {23'h0, sw, 3'h0}, {23'h0, vecSeen});
		$display("test read block done");
		// both pending: receive first, then transmit
		grantEn <= 1'b0;
		wr(dvic_pkg::OFS_CTRL, 32'h3);
		src <= 3'h3;
		repeat (8) @(posedge sys_clk);
		grantEn <= 1'b1;
		wait_busy();
		src <= 3'h1;
		nVec = nVec + 8'h1;
		wait_vec(nVec);
		chk("first", {23'h0, sw, 3'h0}, {23'h0, vecSeen});
		wait_busy();
		src <= 3'h0;
		nVec = nVec + 8'h1;
		wait_vec(nVec);
		chk("second", {23'h0, sw, 3'h4}, {23'h0, vecSeen});
		$display("test priority done");
		// idle device passes the grant on
		@(posedge sys_clk);
		passGnt <= 1'b1;
		@(posedge sys_clk);
		#1 chk("pass", 32'h1, {31'h0, busGrantOut});
		@(posedge sys_clk);
		passGnt <= 1'b0;
		$display("test grant pass done");
		test_done();
	end
endmodule : tb_dual_vector_interrupt_control

bind dvic_top dvic_top_checker chk_u (.sys_clk(sys_clk), .rst(rst),
	.busRequest(busRequest), .busGrantIn(busGrantIn),
	.busGrantOut(busGrantOut), .busBusy(busBusy),
	.vectorTaken(vectorTaken), .vectorData(vectorData),
	.vectorDataOe(vectorDataOe), .vectorSwitch(vectorSwitch));
